// ==== include/adaptive_eq_defines.svh ====
// register offsets, field positions, reset values and limits
`ifndef ADAPTIVE_EQ_DEFINES_SVH
`define ADAPTIVE_EQ_DEFINES_SVH
`define OFS_RSVD_A 8'h3b
`define OFS_RSVD_B 8'h3c
`define OFS_RSVD_C 8'h3d
`define OFS_RSVD_D 8'h3e
`define OFS_RSVD_E 8'h3f
`define OFS_RSVD_F 8'h40
`define OFS_SF_LIMITS 8'h41
`define OFS_ADAPT_CTRL 8'h42
`define OFS_ERR_THRESH 8'h43
`define RST_RSVD_A 8'h01
`define RST_RSVD_B 8'h14
`define RST_RSVD_C 8'h6f
`define RST_RSVD_D 8'h00
`define RST_RSVD_E 8'h40
`define RST_RSVD_F 8'h00
`define RST_UPPER 4'ha
`define RST_LOWER 4'h7
`define RST_ERR_SEL 3'h7
`define RST_FILTER_EN 1'b1
`define RST_ERR_THRESH 8'h01
`define UPPER_HI 7
`define UPPER_LO 4
`define LOWER_HI 3
`define LOWER_LO 0
`define ERR_SEL_HI 6
`define ERR_SEL_LO 4
`define CTRL_RSVD_BIT 3
`define TWO_STEP_BIT 2
`define LOOP_ORDER_BIT 1
`define FILTER_EN_BIT 0
`define ERR_CLOCK_BIT 2
`define ERR_ENCODE_BIT 1
`define ERR_PARITY_BIT 0
`define SF_MIDPOINT 4'h7
`define SF_LEGAL_MAX 4'he
`define ERR_COUNT_MAX 8'hff
`endif

// ==== include/adaptive_eq_pkg.sv ====
// types shared by the equalizer search logic
package adaptive_eq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_HOLD   = 5'b00100,
    ST_VERIFY = 5'b01000,
    ST_TRACK  = 5'b10000
  } search_state_t;
  typedef logic [3:0] filter_val_t;
endpackage : adaptive_eq_pkg

// ==== include/eq_window_if.sv ====
// carrier between the search engine and the error window counter
`timescale 1ns/1ns
interface eq_window_if #(parameter int PERIOD_W = 16);
  logic restart;
  logic [PERIOD_W-1:0] half_cycles;
  logic [2:0] err_select;
  logic [2:0] err_in;
  logic err_hit;
  logic half_done;
  logic [7:0] err_count;
  modport window (
    input restart, half_cycles, err_select, err_in,
    output err_hit, half_done, err_count
  );
  modport search (
    output restart, half_cycles, err_select, err_in,
    input err_hit, half_done, err_count
  );
endinterface : eq_window_if

// ==== rtl/eq_error_window.sv ====
// half-period timer and selected-error accumulator
`timescale 1ns/1ns
`include "adaptive_eq_defines.svh"
module eq_error_window #(
  parameter int PERIOD_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  eq_window_if.window win
);
  import adaptive_eq_pkg::*;

  logic [PERIOD_W-1:0] timer;
  logic [2:0] hits;
  logic [1:0] hit_num;
  logic [8:0] next_count;
  logic done_q;
  logic [7:0] count_q;

  // only error classes enabled in the select field are counted
  assign hits = win.err_in & win.err_select;
  assign hit_num = 2'(hits[0]) + 2'(hits[1]) + 2'(hits[2]);
  assign win.err_hit = |hits;
  assign win.half_done = done_q;
  assign win.err_count = count_q;

  // half-period timer; a zero period still yields one-cycle windows
  always_ff @(posedge clk) begin
    if (sys_rst || win.restart) begin
      timer <= '0;
      done_q <= 1'b0;
    end else if (timer + 1'b1 >= win.half_cycles) begin
      timer <= '0;
      done_q <= 1'b1;
    end else begin
      timer <= timer + 1'b1;
      done_q <= 1'b0;
    end
  end

  // next accumulator value; a fresh window starts from this cycle's hits
  always_comb begin
    if (done_q) begin
      next_count = {7'h00, hit_num};
    end else begin
      next_count = {1'b0, count_q} + {7'h00, hit_num};
    end
  end

  // accumulator restarts with each window so counts stay per-setting
  always_ff @(posedge clk) begin
    if (sys_rst || win.restart) begin
      count_q <= '0;
    end else begin
      // saturate rather than wrap so a noisy link never looks clean
      if (next_count > {1'b0, `ERR_COUNT_MAX}) begin
        count_q <= `ERR_COUNT_MAX;
      end else begin
        count_q <= next_count[7:0];
      end
    end
  end
endmodule : eq_error_window

// ==== rtl/adaptive_eq_sample_control.sv ====
// adaptive equalizer and sample filter search with its register set
// How it works
// - upper filter limit bits 7:4, reset 0xA
// - lower filter limit bits 3:0, reset 0x7
// - filter setting held inside programmed limits when lower <= upper <= 0xE
// - any error-select bit set enables error checking
// - bits select clock, encoding and parity errors
// - errors accumulate over half the relock period
// - count above threshold steps to the next sweep point while settling, and steps only the equalizer (holding at top) while tracking
// - one-step mode: full wait, then check lock
// - two-step mode: half wait, half error check
// - error in second half advances immediately
// - loop-order bit picks which loop is inner
// - filter adaptation only while its enable set
`timescale 1ns/1ns
`include "adaptive_eq_defines.svh"
module adaptive_eq_sample_control #(
  parameter int EQ_W = 4,
  parameter logic [EQ_W-1:0] EQ_MAX = '1,
  parameter int PERIOD_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [PERIOD_W-1:0] relock_period,
  input wire logic adapt_start,
  input wire logic link_clock_err,
  input wire logic link_encode_err,
  input wire logic link_parity_err,
  input wire logic link_locked,
  output logic [EQ_W-1:0] eq_setting,
  output adaptive_eq_pkg::filter_val_t sample_filter_setting,
  output logic adapt_busy,
  output logic adapt_valid
);
  import adaptive_eq_pkg::*;

  // refuse shapes the stepping logic cannot serve
  generate
    if (EQ_W < 1 || PERIOD_W < 2) begin : g_bad_params
      $error("adaptive_eq_sample_control: bad parameters");
    end
  endgenerate

  logic [7:0] rsvd_regs [0:5];
  filter_val_t upper_limit;
  filter_val_t lower_limit;
  logic [2:0] err_sel;
  logic ctrl_rsvd;
  logic two_step;
  logic loop_order;
  logic filter_adapt_en;
  logic [7:0] err_thresh;
  search_state_t state;
  logic [EQ_W-1:0] eq_idx;
  filter_val_t sf_idx;
  filter_val_t sf_clamped;
  logic [EQ_W-1:0] next_eq;
  filter_val_t next_sf;
  logic restart_q;
  logic win_done;
  logic check_en;
  logic over_thresh;
  logic advance;
  logic accept;
  logic retune;
  logic eq_wrap;
  logic sf_wrap;

  eq_window_if #(.PERIOD_W(PERIOD_W)) win ();

  eq_error_window #(.PERIOD_W(PERIOD_W)) u_window (
    .clk(clk),
    .sys_rst(sys_rst),
    .win(win)
  );

  // reset values of the six reserved read-write registers
  localparam logic [7:0] RSVD_RST [0:5] = '{`RST_RSVD_A, `RST_RSVD_B,
    `RST_RSVD_C, `RST_RSVD_D, `RST_RSVD_E, `RST_RSVD_F};

  // reserved registers keep whatever software writes
  for (genvar i = 0; i < 6; i++) begin : g_rsvd
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rsvd_regs[i] <= RSVD_RST[i];
      end else if (reg_wr_en && reg_addr == `OFS_RSVD_A + 8'(i)) begin
        rsvd_regs[i] <= reg_wdata;
      end
    end
  end

  // filter limit register; ordering of the limits is software's duty
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upper_limit <= `RST_UPPER;
      lower_limit <= `RST_LOWER;
    end else if (reg_wr_en && reg_addr == `OFS_SF_LIMITS) begin
      upper_limit <= reg_wdata[`UPPER_HI:`UPPER_LO];
      lower_limit <= reg_wdata[`LOWER_HI:`LOWER_LO];
    end
  end

  // adaptation control register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_sel <= `RST_ERR_SEL;
      ctrl_rsvd <= 1'b0;
      two_step <= 1'b0;
      loop_order <= 1'b0;
      filter_adapt_en <= `RST_FILTER_EN;
    end else if (reg_wr_en && reg_addr == `OFS_ADAPT_CTRL) begin
      err_sel <= reg_wdata[`ERR_SEL_HI:`ERR_SEL_LO];
      ctrl_rsvd <= reg_wdata[`CTRL_RSVD_BIT];
      two_step <= reg_wdata[`TWO_STEP_BIT];
      loop_order <= reg_wdata[`LOOP_ORDER_BIT];
      filter_adapt_en <= reg_wdata[`FILTER_EN_BIT];
    end
  end

  // error threshold; a zero value would retune on any single error
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_thresh <= `RST_ERR_THRESH;
    end else if (reg_wr_en && reg_addr == `OFS_ERR_THRESH) begin
      err_thresh <= reg_wdata;
    end
  end

  // registered read port; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `OFS_RSVD_A: reg_rdata <= rsvd_regs[0];
        `OFS_RSVD_B: reg_rdata <= rsvd_regs[1];
        `OFS_RSVD_C: reg_rdata <= rsvd_regs[2];
        `OFS_RSVD_D: reg_rdata <= rsvd_regs[3];
        `OFS_RSVD_E: reg_rdata <= rsvd_regs[4];
        `OFS_RSVD_F: reg_rdata <= rsvd_regs[5];
        `OFS_SF_LIMITS: reg_rdata <= {upper_limit, lower_limit};
        `OFS_ADAPT_CTRL: begin
          reg_rdata <= {1'b0, err_sel, ctrl_rsvd, two_step, loop_order,
            filter_adapt_en};
        end
        `OFS_ERR_THRESH: reg_rdata <= err_thresh;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // window inputs: half the relock period, selected error classes
  assign win.restart = restart_q;
  assign win.half_cycles = relock_period >> 1;
  assign win.err_select = err_sel;
  assign win.err_in[`ERR_CLOCK_BIT] = link_clock_err;
  assign win.err_in[`ERR_ENCODE_BIT] = link_encode_err;
  assign win.err_in[`ERR_PARITY_BIT] = link_parity_err;

  // checking is off when no error class is selected
  assign check_en = |err_sel;
  assign over_thresh = check_en && (win.err_count > err_thresh);

  // the window restarts one edge after a new setting, so its end flag and
  // count still belong to the old window while the restart is pending
  assign win_done = win.half_done && !restart_q;

  // per-state decisions for the current setting
  always_comb begin
    advance = 1'b0;
    accept = 1'b0;
    retune = 1'b0;
    case (state)
      ST_SETTLE: begin
        advance = win_done && over_thresh;
      end
      ST_HOLD: begin
        // one-step judges only the lock level at the end of the wait
        accept = win_done && link_locked;
        advance = win_done && !link_locked;
      end
      ST_VERIFY: begin
        // the check window is abandoned on the first error
        advance = check_en && win.err_hit;
        accept = win_done && !advance;
      end
      ST_TRACK: begin
        retune = win_done && over_thresh;
      end
      default: begin
        advance = 1'b0;
      end
    endcase
  end

  // next point of the nested sweep
  assign eq_wrap = (eq_idx >= EQ_MAX);
  assign sf_wrap = (sf_idx >= upper_limit);
  always_comb begin
    next_eq = eq_idx;
    next_sf = sf_idx;
    if (!filter_adapt_en) begin
      next_eq = eq_wrap ? '0 : eq_idx + 1'b1;
    end else if (!loop_order) begin
      // equalizer inner, filter outer
      next_eq = eq_wrap ? '0 : eq_idx + 1'b1;
      if (eq_wrap) begin
        next_sf = sf_wrap ? lower_limit : sf_idx + 1'b1;
      end
    end else begin
      // filter inner, equalizer outer
      next_sf = sf_wrap ? lower_limit : sf_idx + 1'b1;
      if (sf_wrap) begin
        next_eq = eq_wrap ? '0 : eq_idx + 1'b1;
      end
    end
  end

  // search state machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else if (adapt_start) begin
      state <= ST_SETTLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_SETTLE: begin
          if (advance) begin
            state <= ST_SETTLE;
          end else if (win_done) begin
            state <= two_step ? ST_VERIFY : ST_HOLD;
          end
        end
        ST_HOLD, ST_VERIFY: begin
          if (advance) begin
            state <= ST_SETTLE;
          end else if (accept) begin
            state <= ST_TRACK;
          end
        end
        ST_TRACK: begin
          if (retune) begin
            state <= ST_SETTLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // settings and window restarts follow the decisions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eq_idx <= '0;
      sf_idx <= `SF_MIDPOINT;
      restart_q <= 1'b0;
    end else if (adapt_start) begin
      eq_idx <= '0;
      sf_idx <= filter_adapt_en ? lower_limit : `SF_MIDPOINT;
      restart_q <= 1'b1;
    end else if (advance) begin
      eq_idx <= next_eq;
      sf_idx <= filter_adapt_en ? next_sf : `SF_MIDPOINT;
      restart_q <= 1'b1;
    end else if (retune) begin
      // at the top setting the equalizer stays and the search re-checks
      eq_idx <= eq_wrap ? eq_idx : eq_idx + 1'b1;
      restart_q <= 1'b1;
    end else begin
      restart_q <= 1'b0;
    end
  end

  // clamp to the limits so a limit rewrite takes effect at once
  always_comb begin
    sf_clamped = sf_idx;
    if (sf_clamped > upper_limit) begin
      sf_clamped = upper_limit;
    end
    if (sf_clamped < lower_limit) begin
      sf_clamped = lower_limit;
    end
    if (sf_clamped > `SF_LEGAL_MAX) begin
      sf_clamped = `SF_LEGAL_MAX;
    end
  end

  // registered outputs toward the receiver
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eq_setting <= '0;
      sample_filter_setting <= `SF_MIDPOINT;
      adapt_busy <= 1'b0;
      adapt_valid <= 1'b0;
    end else begin
      eq_setting <= eq_idx;
      sample_filter_setting <= sf_clamped;
      adapt_busy <= (state != ST_IDLE) && (state != ST_TRACK);
      adapt_valid <= (state == ST_TRACK);
    end
  end
endmodule : adaptive_eq_sample_control

// ==== dv/link_partner.sv ====
// stand-in for the remote serializer: error classes and lock level
`timescale 1ns/1ns
module link_partner (
  input wire logic [2:0] err_mode,
  input wire logic lock_mode,
  output logic clock_err,
  output logic encode_err,
  output logic parity_err,
  output logic locked
);
  // errors stay up every cycle while commanded, so a window of n cycles
  // sees exactly n of each class; the link has no idea where windows begin
  assign clock_err = err_mode[2];
  assign encode_err = err_mode[1];
  assign parity_err = err_mode[0];
  assign locked = lock_mode;
endmodule : link_partner

// ==== dv/adaptive_eq_sample_control_sva.sv ====
// port-level checks for the sample control block
`timescale 1ns/1ns
module adaptive_eq_sample_control_sva #(
  parameter int EQ_W = 4,
  parameter int PERIOD_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic adapt_start,
  input wire logic [EQ_W-1:0] eq_setting,
  input wire adaptive_eq_pkg::filter_val_t sample_filter_setting,
  input wire logic adapt_busy,
  input wire logic adapt_valid
);
  import adaptive_eq_pkg::*;
  logic [3:0] hi;
  logic [3:0] lo;
  logic fen;
  logic [1:0] age;
  logic cfg_wr;
  assign cfg_wr = reg_wr_en && (reg_addr == 8'h41 || reg_addr == 8'h42);
  // mirror of limits and filter enable, so checks follow software writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi <= 4'ha;
      lo <= 4'h7;
      fen <= 1'b1;
    end else if (reg_wr_en && reg_addr == 8'h41) begin
      hi <= reg_wdata[7:4];
      lo <= reg_wdata[3:0];
    end else if (reg_wr_en && reg_addr == 8'h42) begin
      fen <= reg_wdata[0];
    end
  end
  // cycles since a config write; the clamp is registered, so allow a lag
  always_ff @(posedge clk) begin
    if (sys_rst || cfg_wr) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_rdata_hold: assert property (
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (
    reg_rd_en && (reg_addr < 8'h3b || reg_addr > 8'h43) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_top_bit: assert property (
    reg_rd_en && reg_addr == 8'h42 |=> !reg_rdata[7])
    else $error("control top bit read as one");
  chk_limits_read: assert property (
    reg_rd_en && !reg_wr_en && reg_addr == 8'h41 |=> reg_rdata == {hi, lo})
    else $error("limit register readback wrong");
  chk_start_busy: assert property (
    adapt_start |-> ##2 adapt_busy && !adapt_valid)
    else $error("search not busy after start");
  chk_start_eq_zero: assert property (
    adapt_start |-> ##2 eq_setting == '0)
    else $error("search did not begin at lowest setting");
  chk_start_sf_lower: assert property (
    adapt_start && fen && age != 2'h0 && hi >= lo && hi <= 4'he
    |-> ##2 sample_filter_setting == lo)
    else $error("filter search did not begin at lower limit");
  chk_filter_fixed: assert property (
    adapt_start && !fen && age != 2'h0 && lo <= 4'h7 && hi >= 4'h7
    |-> ##2 sample_filter_setting == 4'h7 [*3])
    else $error("filter moved while adaptation disabled");
  chk_sf_range: assert property (
    age == 2'h3 && hi >= lo
    |-> sample_filter_setting >= lo && sample_filter_setting <= hi)
    else $error("filter setting outside limits");
  chk_sf_legal: assert property (
    sample_filter_setting <= 4'he)
    else $error("filter setting above fourteen");
  cover property (adapt_start ##2 adapt_busy);
  cover property ($rose(adapt_valid));
  cover property (adapt_busy && $changed(eq_setting));
endmodule : adaptive_eq_sample_control_sva

// ==== dv/adaptive_eq_sample_control_tb.sv ====
// register and search sequences for the sample control block
`timescale 1ns/1ns
module adaptive_eq_sample_control_tb;
  import adaptive_eq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] relock_period = 16'h0008;
  logic adapt_start = 1'b0;
  logic [2:0] err_mode = 3'h0;
  logic lock_mode = 1'b0;
  logic clock_err, encode_err, parity_err, locked;
  logic [3:0] eq_setting;
  filter_val_t sample_filter_setting;
  logic adapt_busy, adapt_valid;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] rst_tab [9] = '{8'h01, 8'h14, 8'h6f, 8'h00, 8'h40, 8'h00,
    8'ha7, 8'h71, 8'h01};
  always #5 clk = ~clk;
  link_partner far_end (.err_mode(err_mode), .lock_mode(lock_mode),
    .clock_err(clock_err), .encode_err(encode_err),
    .parity_err(parity_err), .locked(locked));
  adaptive_eq_sample_control dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .relock_period(relock_period), .adapt_start(adapt_start),
    .link_clock_err(clock_err), .link_encode_err(encode_err),
    .link_parity_err(parity_err), .link_locked(locked),
    .eq_setting(eq_setting), .sample_filter_setting(sample_filter_setting),
    .adapt_busy(adapt_busy), .adapt_valid(adapt_valid));
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    check("reg_rdata", exp, reg_rdata);
  endtask : rd
  // start a search and stop at acceptance or at the first step; the bound
  // is loose against two half windows of four cycles
  task automatic run(input logic [7:0] ctrl, input logic [2:0] errs,
    input logic lk, input logic ok, input logic [3:0] eq,
    input logic [3:0] sf);
    int n;
    logic [3:0] s;
    wr(8'h42, ctrl);
    err_mode = errs;
    lock_mode = lk;
    @(negedge clk);
    adapt_start = 1'b1;
    @(negedge clk);
    adapt_start = 1'b0;
    repeat (2) @(negedge clk);
    s = sample_filter_setting;
    n = 0;
    while (n < 60 && adapt_valid !== 1'b1 && eq_setting === 4'h0 &&
      sample_filter_setting === s) begin
      @(negedge clk);
      n++;
    end
    check("adapt_valid", {7'h00, ok}, {7'h00, adapt_valid});
    check("eq_setting", {4'h0, eq}, {4'h0, eq_setting});
    check("sample_filter_setting", {4'h0, sf},
      {4'h0, sample_filter_setting});
  endtask : run
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // watchdog: the whole sequence needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(8'(8'h3b + i), rst_tab[i]);
    end
    rd(8'h44, 8'h00);
    rd(8'h3a, 8'h00);
    wr(8'h3d, 8'h5a);
    rd(8'h3d, 8'h5a);
    wr(8'h42, 8'hff);
    rd(8'h42, 8'h7f);
    run(8'h70, 3'h0, 1'b0, 1'b0, 4'h1, 4'h7);
    run(8'h71, 3'h0, 1'b1, 1'b1, 4'h0, 4'h7);
    wr(8'h41, 8'ha9);
    rd(8'h41, 8'ha9);
    run(8'h71, 3'h0, 1'b0, 1'b0, 4'h1, 4'h9);
    run(8'h73, 3'h0, 1'b0, 1'b0, 4'h0, 4'ha);
    run(8'h75, 3'h0, 1'b0, 1'b1, 4'h0, 4'h9);
    // each error class alone, selected alone, must push the search on
    for (int i = 0; i < 3; i++) begin
      run(8'h05 | (8'h10 << i), 3'(1 << i), 1'b1, 1'b0,
        4'h1, 4'h9);
    end
    run(8'h15, 3'h6, 1'b1, 1'b1, 4'h0, 4'h9);
    run(8'h05, 3'h7, 1'b0, 1'b1, 4'h0, 4'h9);
    wr(8'h43, 8'h04);
    run(8'h41, 3'h4, 1'b1, 1'b1, 4'h0, 4'h9);
    // tracking windows hold four errors each; a stale count would step
    repeat (20) @(negedge clk);
    check("eq_setting", 8'h00, {4'h0, eq_setting});
    // settle passes at four errors, the check half must then give up
    run(8'h45, 3'h4, 1'b1, 1'b0, 4'h1, 4'h9);
    // a longer period makes five errors per half window, above four
    relock_period = 16'h000a;
    run(8'h41, 3'h4, 1'b1, 1'b0, 4'h1, 4'h9);
    relock_period = 16'h0008;
    wr(8'h43, 8'h03);
    run(8'h41, 3'h4, 1'b1, 1'b0, 4'h1, 4'h9);
    print_verdict();
  end
endmodule : adaptive_eq_sample_control_tb
bind adaptive_eq_sample_control adaptive_eq_sample_control_sva #(
  .EQ_W(EQ_W), .PERIOD_W(PERIOD_W)) u_sva (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
  .adapt_start(adapt_start), .eq_setting(eq_setting),
  .sample_filter_setting(sample_filter_setting),
  .adapt_busy(adapt_busy), .adapt_valid(adapt_valid));
